/* logic/rxcke_top.sv */
// Receive edge select and single-frequency clock steering with AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
// How it works
// - With edge select low in hardware mode each lane updates its data outputs as its clock rises.
// - With edge select high in hardware mode each lane updates its data outputs as its clock falls.
// - The edge select pin configures the edge only in hardware mode and is chip select in host mode.
// - One edge setting drives all three lanes alike, with no per-lane override.
// - In single-rail operation the violation output moves on the same selected edge.
// - Single-frequency enable high in hardware mode turns the synthesizer on, fed by the shared 12.288MHz input.
// - In single-frequency mode each lane gets the synthesized clock of its own configured rate.
// - The single-frequency enable reads low when left undriven, so the mode starts disabled.
// - In host mode the neighbouring pins carry serial data in and serial data out.
module rxcke_top #(
  parameter int NCH = rxcke_pkg::NUM_CHANNELS,
  parameter int HALF_CYCLES = rxcke_pkg::RCLK_HALF_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  // AXI4-Lite slave
  input wire logic [rxcke_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [rxcke_pkg::AXI_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [rxcke_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [rxcke_pkg::AXI_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Configuration pins
  input wire logic host_mode_pin,
  input wire logic rx_edge_select,
  input wire logic single_freq_enable,
  input wire logic rx_on_pin,
  input wire logic rx_monitor_pin_in,
  output logic rx_monitor_pin_out,
  output logic rx_monitor_pin_oe,
  // Serial interface engine side
  input wire logic serial_data_out,
  output logic serial_chip_select_n,
  output logic serial_data_in,
  // Recovered bits from clock recovery
  input wire logic [NCH-1:0] rx_bit_strobe,
  input wire rxcke_pkg::rxcke_bits_t [NCH-1:0] rx_bits,
  // Toward the framer
  output logic [NCH-1:0] rx_clock_out,
  output logic [NCH-1:0] rx_positive_data,
  output logic [NCH-1:0] rx_negative_data_or_violation,
  // Clock steering
  output logic synth_enable,
  output rxcke_pkg::rxcke_src_t [NCH-1:0] clk_source_sel,
  output rxcke_pkg::rxcke_rate_t [NCH-1:0] synth_rate,
  output logic rx_on_level,
  output logic rx_monitor_level
);
  // Pin synchroniser
  logic [rxcke_pkg::SYN_W-1:0] sync_a_q, sync_b_q;
  logic [rxcke_pkg::SYN_W-1:0] pins;

  // Register file
  rxcke_pkg::rxcke_ctrl_t ctrl_q, ctrl_d;
  logic [2*NCH-1:0] rate_q, rate_d;

  // Write channel
  logic awready_q, awready_d;
  logic wready_q, wready_d;
  logic aw_have_q, aw_have_d;
  logic w_have_q, w_have_d;
  logic [rxcke_pkg::AXI_ADDR_W-1:0] waddr_q, waddr_d;
  logic [rxcke_pkg::AXI_DATA_W-1:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;

  // Read channel
  logic arready_q, arready_d;
  logic rvalid_q, rvalid_d;
  logic [rxcke_pkg::AXI_DATA_W-1:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;
  logic [rxcke_pkg::AXI_DATA_W-1:0] status_word;

  // Effective configuration and steering
  logic host_mode;
  logic edge_eff_q, edge_eff_d;
  logic sfm_eff_q, sfm_eff_d;
  logic rail_q, rail_d;
  logic rx_on_q, rx_on_d;
  logic mon_q, mon_d;
  logic cs_n_q, cs_n_d;
  logic sdi_q, sdi_d;
  logic mon_out_q, mon_out_d;
  logic mon_oe_q, mon_oe_d;
  rxcke_pkg::rxcke_src_t [NCH-1:0] sel_q, sel_d;
  rxcke_pkg::rxcke_rate_t [NCH-1:0] srate_q, srate_d;

  // Two flops per pin; stage one resets low so a floating enable reads off
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sync_a_q <= rxcke_pkg::SYN_RESET;
      sync_b_q <= rxcke_pkg::SYN_RESET;
    end else begin
      sync_a_q <= {rx_monitor_pin_in, rx_on_pin, single_freq_enable, rx_edge_select,
                   host_mode_pin};
      sync_b_q <= sync_a_q;
    end
  end

  assign pins = sync_b_q;
  assign host_mode = pins[rxcke_pkg::SYN_HOST];

  // AXI write path: address and data taken in either order
  always_comb begin
    awready_d = awready_q;
    wready_d = wready_q;
    aw_have_d = aw_have_q;
    w_have_d = w_have_q;
    waddr_d = waddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    ctrl_d = ctrl_q;
    rate_d = rate_q;
    if (s_axi_awvalid && awready_q) begin
      aw_have_d = 1'b1;
      waddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_q) begin
      w_have_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (aw_have_q && w_have_q && !bvalid_q) begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = rxcke_pkg::RESP_OKAY;
      if (waddr_q == rxcke_pkg::REG_CTRL_OFF) begin
        if (wstrb_q[0]) begin
          ctrl_d = rxcke_pkg::rxcke_ctrl_t'(wdata_q[rxcke_pkg::CTRL_W-1:0]);
        end
      end else if (waddr_q == rxcke_pkg::REG_RATE_OFF) begin
        if (wstrb_q[0]) begin
          rate_d = wdata_q[2*NCH-1:0];
        end
      end else if (waddr_q == rxcke_pkg::REG_STATUS_OFF) begin
        bresp_d = rxcke_pkg::RESP_OKAY;
      end else begin
        bresp_d = rxcke_pkg::RESP_SLVERR;
      end
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    // Ready is registered, so one item per channel until the response is gone
    awready_d = !aw_have_d && !bvalid_d;
    wready_d = !w_have_d && !bvalid_d;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      waddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= rxcke_pkg::RESP_OKAY;
      ctrl_q <= rxcke_pkg::rxcke_ctrl_t'(rxcke_pkg::CTRL_RESET);
      rate_q <= rxcke_pkg::RATE_RESET;
    end else begin
      awready_q <= awready_d;
      wready_q <= wready_d;
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      waddr_q <= waddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      ctrl_q <= ctrl_d;
      rate_q <= rate_d;
    end
  end

  // Status word shows what the lanes really use
  always_comb begin
    status_word = '0;
    status_word[rxcke_pkg::STAT_HOST_BIT] = host_mode;
    status_word[rxcke_pkg::STAT_EDGE_BIT] = edge_eff_q;
    status_word[rxcke_pkg::STAT_SFM_BIT] = sfm_eff_q;
    status_word[rxcke_pkg::STAT_RXON_BIT] = rx_on_q;
    status_word[rxcke_pkg::STAT_MON_BIT] = mon_q;
    status_word[rxcke_pkg::STAT_SEL_LSB +: 2*NCH] = sel_q;
  end

  // AXI read path, one read in flight
  always_comb begin
    arready_d = arready_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (s_axi_arvalid && arready_q) begin
      arready_d = 1'b0;
      rvalid_d = 1'b1;
      rresp_d = rxcke_pkg::RESP_OKAY;
      rdata_d = '0;
      if (s_axi_araddr == rxcke_pkg::REG_CTRL_OFF) begin
        rdata_d[rxcke_pkg::CTRL_W-1:0] = ctrl_q;
      end else if (s_axi_araddr == rxcke_pkg::REG_RATE_OFF) begin
        rdata_d[2*NCH-1:0] = rate_q;
      end else if (s_axi_araddr == rxcke_pkg::REG_STATUS_OFF) begin
        rdata_d = status_word;
      end else begin
        rresp_d = rxcke_pkg::RESP_SLVERR;
      end
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
      arready_d = 1'b1;
      rdata_d = '0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= rxcke_pkg::RESP_OKAY;
    end else begin
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  // Pin or register source per mode; pins are assumed static while lanes run
  always_comb begin
    if (host_mode) begin
      edge_eff_d = ctrl_q.edge_falling;
      sfm_eff_d = ctrl_q.sfm;
      rx_on_d = ctrl_q.rx_on;
      mon_d = ctrl_q.rx_monitor;
      cs_n_d = pins[rxcke_pkg::SYN_EDGE];
      sdi_d = pins[rxcke_pkg::SYN_RXON];
      mon_out_d = serial_data_out;
      mon_oe_d = 1'b1;
    end else begin
      edge_eff_d = pins[rxcke_pkg::SYN_EDGE];
      sfm_eff_d = pins[rxcke_pkg::SYN_SFM];
      rx_on_d = pins[rxcke_pkg::SYN_RXON];
      mon_d = pins[rxcke_pkg::SYN_MON];
      cs_n_d = 1'b1;
      sdi_d = 1'b0;
      mon_out_d = 1'b0;
      mon_oe_d = 1'b0;
    end
    rail_d = ctrl_q.single_rail;
    // Each lane follows its own rate; the enable picks synthesizer or reference
    for (int i = 0; i < NCH; i++) begin
      srate_d[i] = rxcke_pkg::rxcke_rate_t'(rate_q[2*i +: 2]);
      if (sfm_eff_d) begin
        sel_d[i] = rxcke_pkg::RXCKE_SRC_SYNTH;
      end else if (srate_d[i] == rxcke_pkg::RXCKE_RATE_DS3) begin
        sel_d[i] = rxcke_pkg::RXCKE_SRC_REF_B;
      end else if (srate_d[i] == rxcke_pkg::RXCKE_RATE_STS1) begin
        sel_d[i] = rxcke_pkg::RXCKE_SRC_REF_C;
      end else begin
        sel_d[i] = rxcke_pkg::RXCKE_SRC_REF_A;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      edge_eff_q <= 1'b0;
      sfm_eff_q <= 1'b0;
      rail_q <= 1'b0;
      rx_on_q <= 1'b0;
      mon_q <= 1'b0;
      cs_n_q <= 1'b1;
      sdi_q <= 1'b0;
      mon_out_q <= 1'b0;
      mon_oe_q <= 1'b0;
      sel_q <= {NCH{rxcke_pkg::RXCKE_SRC_REF_A}};
      srate_q <= {NCH{rxcke_pkg::RXCKE_RATE_E3}};
    end else begin
      edge_eff_q <= edge_eff_d;
      sfm_eff_q <= sfm_eff_d;
      rail_q <= rail_d;
      rx_on_q <= rx_on_d;
      mon_q <= mon_d;
      cs_n_q <= cs_n_d;
      sdi_q <= sdi_d;
      mon_out_q <= mon_out_d;
      mon_oe_q <= mon_oe_d;
      sel_q <= sel_d;
      srate_q <= srate_d;
    end
  end

  // Lanes share one edge setting, no per-lane override
  generate
    for (genvar g = 0; g < NCH; g++) begin : g_lane
      rxcke_pkg::rxcke_out_t lane_bits;
      rxcke_lane #(
        .HALF_CYCLES(HALF_CYCLES)
      ) u_lane (
        .core_clk(core_clk),
        .rst(rst),
        .bit_strobe(rx_bit_strobe[g]),
        .bit_in(rx_bits[g]),
        .edge_falling(edge_eff_q),
        .single_rail(rail_q),
        .rclk_out(rx_clock_out[g]),
        .bits_out(lane_bits)
      );
      assign rx_positive_data[g] = lane_bits.positive_data;
      assign rx_negative_data_or_violation[g] = lane_bits.negative_data_or_violation;
    end
  endgenerate

  // Bus outputs straight from their flops
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // Pin and steering outputs straight from their flops
  assign rx_monitor_pin_out = mon_out_q;
  assign rx_monitor_pin_oe = mon_oe_q;
  assign serial_chip_select_n = cs_n_q;
  assign serial_data_in = sdi_q;
  assign synth_enable = sfm_eff_q;
  assign clk_source_sel = sel_q;
  assign synth_rate = srate_q;
  assign rx_on_level = rx_on_q;
  assign rx_monitor_level = mon_q;
endmodule
`default_nettype wire

/* shared/rxcke_pkg.sv */
// Package: constants, register map and types for the receive edge and single-frequency block
`default_nettype none
package rxcke_pkg;
  // Channel count and bus widths
  localparam int NUM_CHANNELS = 3;
  localparam int AXI_ADDR_W = 4;
  localparam int AXI_DATA_W = 32;

  // Register byte offsets
  localparam logic [3:0] REG_CTRL_OFF = 4'h0;
  localparam logic [3:0] REG_RATE_OFF = 4'h4;
  localparam logic [3:0] REG_STATUS_OFF = 4'h8;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Control word width and reset values of the control and rate registers
  localparam int CTRL_W = 5;
  localparam logic [4:0] CTRL_RESET = 5'h00;
  localparam logic [5:0] RATE_RESET = 6'h00;

  // Status field positions
  localparam int STAT_HOST_BIT = 0;
  localparam int STAT_EDGE_BIT = 1;
  localparam int STAT_SFM_BIT = 2;
  localparam int STAT_RXON_BIT = 3;
  localparam int STAT_MON_BIT = 4;
  localparam int STAT_SEL_LSB = 8;

  // Pin synchroniser slots
  localparam int SYN_HOST = 0;
  localparam int SYN_EDGE = 1;
  localparam int SYN_SFM = 2;
  localparam int SYN_RXON = 3;
  localparam int SYN_MON = 4;
  localparam int SYN_W = 5;
  localparam logic [4:0] SYN_RESET = 5'h00;

  // Reference frequencies in kHz, for the clock plan
  localparam int SYNTH_REF_KHZ = 12288;
  localparam int RATE_E3_KHZ = 34368;
  localparam int RATE_DS3_KHZ = 44736;
  localparam int RATE_STS1_KHZ = 51840;

  // Half period of the recovered clock output, in core cycles
  localparam int RCLK_HALF_CYCLES = 1;

  // Line rate of a channel
  typedef enum logic [1:0] {
    RXCKE_RATE_E3 = 2'b00,
    RXCKE_RATE_DS3 = 2'b01,
    RXCKE_RATE_STS1 = 2'b10,
    RXCKE_RATE_RSVD = 2'b11
  } rxcke_rate_t;

  // Clock source steered onto a channel
  typedef enum logic [1:0] {
    RXCKE_SRC_REF_A = 2'b00,
    RXCKE_SRC_REF_B = 2'b01,
    RXCKE_SRC_REF_C = 2'b10,
    RXCKE_SRC_SYNTH = 2'b11
  } rxcke_src_t;

  // Recovered clock output phase
  typedef enum logic [0:0] {
    RXCKE_PH_LOW = 1'b0,
    RXCKE_PH_HIGH = 1'b1
  } rxcke_phase_t;

  // Host-mode control word
  typedef struct packed {
    logic rx_monitor;
    logic rx_on;
    logic single_rail;
    logic sfm;
    logic edge_falling;
  } rxcke_ctrl_t;

  // Recovered bits of one channel
  typedef struct packed {
    logic pos;
    logic neg;
    logic viol;
  } rxcke_bits_t;

  // Bits as presented to the framer
  typedef struct packed {
    logic positive_data;
    logic negative_data_or_violation;
  } rxcke_out_t;
endpackage
`default_nettype wire

/* logic/rxcke_lane.sv */
// One receive lane: recovered clock output and edge-aligned data update
`timescale 1ns/1ps
`default_nettype none
module rxcke_lane #(
  parameter int HALF_CYCLES = rxcke_pkg::RCLK_HALF_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic bit_strobe,
  input wire rxcke_pkg::rxcke_bits_t bit_in,
  input wire logic edge_falling,
  input wire logic single_rail,
  output logic rclk_out,
  output rxcke_pkg::rxcke_out_t bits_out
);
  localparam int CNT_W = (HALF_CYCLES > 1) ? $clog2(HALF_CYCLES) : 1;
  localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(HALF_CYCLES - 1);

  rxcke_pkg::rxcke_phase_t phase_q, phase_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  rxcke_pkg::rxcke_out_t stage_q, stage_d;
  rxcke_pkg::rxcke_out_t out_q, out_d;
  rxcke_pkg::rxcke_out_t mapped;

  // Single rail puts the violation flag on the negative pin
  always_comb begin
    mapped.positive_data = bit_in.pos;
    mapped.negative_data_or_violation = single_rail ? bit_in.viol : bit_in.neg;
  end

  // Clock phase and data update; strobes during the high phase are dropped
  always_comb begin
    phase_d = phase_q;
    cnt_d = cnt_q;
    stage_d = stage_q;
    out_d = out_q;
    case (phase_q)
      rxcke_pkg::RXCKE_PH_LOW: begin
        if (bit_strobe) begin
          phase_d = rxcke_pkg::RXCKE_PH_HIGH;
          cnt_d = CNT_LOAD;
          stage_d = mapped;
          if (!edge_falling) begin
            out_d = mapped;
          end
        end
      end
      rxcke_pkg::RXCKE_PH_HIGH: begin
        if (cnt_q == '0) begin
          phase_d = rxcke_pkg::RXCKE_PH_LOW;
          if (edge_falling) begin
            out_d = stage_q;
          end
        end else begin
          cnt_d = cnt_q - CNT_W'(1);
        end
      end
      default: begin
        phase_d = rxcke_pkg::RXCKE_PH_LOW;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      phase_q <= rxcke_pkg::RXCKE_PH_LOW;
      cnt_q <= '0;
      stage_q <= '0;
      out_q <= '0;
    end else begin
      phase_q <= phase_d;
      cnt_q <= cnt_d;
      stage_q <= stage_d;
      out_q <= out_d;
    end
  end

  // Clock output is the phase flop itself
  assign rclk_out = phase_q;
  assign bits_out = out_q;
endmodule
`default_nettype wire

/* bench/rxcke_framer_model.sv */
// Framer model that captures the recovered lanes
`timescale 1ns/1ps
`default_nettype none
module rxcke_framer_model #(
  parameter int NCH = 3
) (
  input wire logic data_on_fall,
  input wire logic [NCH-1:0] rclk,
  input wire logic [NCH-1:0] pos,
  input wire logic [NCH-1:0] neg,
  output logic [NCH-1:0] cap_pos,
  output logic [NCH-1:0] cap_neg
);
  // Samples on the edge opposite the update, so it never races the data
  for (genvar i = 0; i < NCH; i++) begin : g_lane
    always @(rclk[i]) begin
      if (rclk[i] === data_on_fall) begin
        cap_pos[i] <= pos[i];
        cap_neg[i] <= neg[i];
      end
    end
  end
endmodule
`default_nettype wire

/* bench/rxcke_top_assertions.sv */
// Checker for lane edge timing and pin steering
`timescale 1ns/1ps
`default_nettype none
module rxcke_top_assertions #(
  parameter int NCH = 3,
  parameter int HALF_CYCLES = 1
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic host_mode_pin,
  input wire logic rx_edge_select,
  input wire logic single_freq_enable,
  input wire logic rx_on_pin,
  input wire logic serial_data_out,
  input wire logic serial_chip_select_n,
  input wire logic serial_data_in,
  input wire logic rx_monitor_pin_out,
  input wire logic rx_monitor_pin_oe,
  input wire logic [NCH-1:0] rx_bit_strobe,
  input wire rxcke_pkg::rxcke_bits_t [NCH-1:0] rx_bits,
  input wire logic [NCH-1:0] rx_clock_out,
  input wire logic [NCH-1:0] rx_positive_data,
  input wire logic synth_enable,
  input wire rxcke_pkg::rxcke_src_t [NCH-1:0] clk_source_sel
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic [2:0] stab_q, stab_d;
  logic edge_q;
  logic calm;

  // Edge pin age in hardware mode; bits in flight may still use the old edge
  always_comb begin
    stab_d = stab_q;
    if (host_mode_pin || rx_edge_select != edge_q) stab_d = 3'h0;
    else if (stab_q != 3'h7) stab_d = stab_q + 3'h1;
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      stab_q <= 3'h0;
      edge_q <= 1'b0;
    end else begin
      stab_q <= stab_d;
      edge_q <= rx_edge_select;
    end
  end
  assign calm = (stab_q == 3'h7) && (rx_edge_select == edge_q);

  // Pins held long enough to pass the synchroniser
  sequence hw_sfm_s(logic on);
    (!host_mode_pin && single_freq_enable == on) [*4];
  endsequence
  sequence host_s;
    host_mode_pin [*5];
  endsequence

  rise_update_a: assert property (
    calm && !rx_edge_select && $rose(rx_clock_out[0])
    |-> rx_positive_data[0] == $past(rx_bits[0].pos))
    else $error("lane data not updated on rising clock");
  fall_update_a: assert property (
    calm && rx_edge_select && $fell(rx_clock_out[0])
    |-> rx_positive_data[0] == $past(rx_bits[0].pos, 1 + HALF_CYCLES))
    else $error("lane data not updated on falling clock");
  data_edge_a: assert property (
    calm && $changed(rx_positive_data[2])
    |-> (rx_edge_select ? $fell(rx_clock_out[2]) : $rose(rx_clock_out[2])))
    else $error("lane data moved off the selected edge");
  lanes_alike_a: assert property (
    rx_bit_strobe == 3'h7 && rx_clock_out == 3'h0
    |=> rx_clock_out == 3'h7 ##HALF_CYCLES rx_clock_out == 3'h0)
    else $error("lane clocks differ");
  sfm_on_a: assert property (hw_sfm_s(1'b1) |-> synth_enable
    && clk_source_sel == {NCH{2'h3}})
    else $error("synthesizer not steered in");
  sfm_off_a: assert property (hw_sfm_s(1'b0) |-> !synth_enable
    && clk_source_sel[0] != rxcke_pkg::RXCKE_SRC_SYNTH
    && clk_source_sel[2] != rxcke_pkg::RXCKE_SRC_SYNTH)
    else $error("synthesizer active while disabled");
  cs_host_a: assert property (
    host_s |-> serial_chip_select_n == $past(rx_edge_select, 3))
    else $error("chip select not passed in host mode");
  sdi_host_a: assert property (
    host_s |-> serial_data_in == $past(rx_on_pin, 3) && rx_monitor_pin_oe
    && rx_monitor_pin_out == $past(serial_data_out))
    else $error("serial data pins wrong in host mode");
  hw_pins_a: assert property (
    (!host_mode_pin) [*5] |-> serial_chip_select_n && !rx_monitor_pin_oe && !serial_data_in)
    else $error("serial pins active in hardware mode");
endmodule

bind rxcke_top rxcke_top_assertions #(.NCH(NCH), .HALF_CYCLES(HALF_CYCLES)) u_chk (
  .core_clk, .rst, .host_mode_pin, .rx_edge_select, .single_freq_enable, .rx_on_pin,
  .serial_data_out, .serial_chip_select_n, .serial_data_in, .rx_monitor_pin_out,
  .rx_monitor_pin_oe, .rx_bit_strobe, .rx_bits, .rx_clock_out, .rx_positive_data,
  .synth_enable, .clk_source_sel);
`default_nettype wire

/* bench/tb_rx_clock_edge_and_sfm_select.sv */
// Self-checking bench for receive edge select and clock steering
`timescale 1ns/1ps
`default_nettype none
module tb_rx_clock_edge_and_sfm_select;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic host_mode_pin = 1'b0, rx_edge_select = 1'b0, single_freq_enable = 1'b0;
  logic rx_on_pin = 1'b0, rx_monitor_pin_in = 1'b0, serial_data_out = 1'b0;
  logic rx_monitor_pin_out, rx_monitor_pin_oe, serial_chip_select_n, serial_data_in;
  logic [2:0] rx_bit_strobe = 3'h0;
  rxcke_pkg::rxcke_bits_t [2:0] rx_bits = '0;
  logic [2:0] rx_clock_out, rx_positive_data, rx_negative_data_or_violation;
  logic [2:0] cap_pos, cap_neg;
  logic synth_enable, rx_on_level, rx_monitor_level;
  rxcke_pkg::rxcke_src_t [2:0] clk_source_sel;
  rxcke_pkg::rxcke_rate_t [2:0] synth_rate;
  int failures = 0, n_compared = 0;
  // Lane model
  logic [2:0] m_pos = 3'h0, m_neg = 3'h0;
  logic m_fall = 1'b0, m_rail = 1'b0;
  logic [2:0] q3[$];

  always #25 core_clk = ~core_clk;

  rxcke_top u_dut (.core_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .host_mode_pin, .rx_edge_select,
    .single_freq_enable, .rx_on_pin, .rx_monitor_pin_in, .rx_monitor_pin_out,
    .rx_monitor_pin_oe, .serial_data_out, .serial_chip_select_n, .serial_data_in,
    .rx_bit_strobe, .rx_bits, .rx_clock_out, .rx_positive_data,
    .rx_negative_data_or_violation, .synth_enable, .clk_source_sel, .synth_rate,
    .rx_on_level, .rx_monitor_level);
  rxcke_framer_model u_framer (.data_on_fall(m_fall), .rclk(rx_clock_out),
    .pos(rx_positive_data), .neg(rx_negative_data_or_violation), .cap_pos, .cap_neg);

  task automatic chk_bus(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_lane(input logic [2:0] got, input logic [2:0] exp);
    chk_bus({29'h0, got}, {29'h0, exp});
  endtask
  task automatic conclude();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Master holds each channel until its own handshake
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk_bus(s_axi_bresp, er);
  endtask
  task automatic axi_rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk_bus(s_axi_rdata, ed);
    chk_bus(s_axi_rresp, er);
  endtask

  // One random bit on all lanes
  task automatic lane_bit();
    logic [8:0] b;
    logic [2:0] op, on;
    b = 9'($urandom);
    op = m_pos;
    on = m_neg;
    for (int i = 0; i < 3; i++) begin
      m_pos[i] = b[3*i+2];
      m_neg[i] = m_rail ? b[3*i] : b[3*i+1];
    end
    @(posedge core_clk);
    rx_bits <= b;
    rx_bit_strobe <= 3'h7;
    @(posedge core_clk);
    rx_bit_strobe <= 3'h0;
    rx_bits <= ~b;
    #1;
    chk_lane(rx_clock_out, 3'h7);
    chk_lane(rx_positive_data, m_fall ? op : m_pos);
    chk_lane(rx_negative_data_or_violation, m_fall ? on : m_neg);
    @(posedge core_clk);
    #1;
    chk_lane(rx_clock_out, 3'h0);
    chk_lane(rx_positive_data, m_pos);
    chk_lane(rx_negative_data_or_violation, m_neg);
    chk_lane(cap_pos, m_fall ? op : m_pos);
    chk_lane(cap_neg, m_fall ? on : m_neg);
  endtask

  initial begin
    logic [1:0] r, s;
    logic [2:0] v;
    void'($urandom(32'h0FDC));
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    repeat (3) @(posedge core_clk);
    axi_rd(rxcke_pkg::REG_CTRL_OFF, 32'h0, rxcke_pkg::RESP_OKAY);
    axi_rd(4'hC, 32'h0, rxcke_pkg::RESP_SLVERR);
    axi_wr(4'hC, 32'h1F, rxcke_pkg::RESP_SLVERR);
    axi_wr(rxcke_pkg::REG_STATUS_OFF, 32'hFFFFFFFF, rxcke_pkg::RESP_OKAY);
    // Every rate code with the synthesizer off, then on
    for (int k = 0; k < 8; k++) begin
      r = 2'(k % 4);
      s = (r == 2'h3) ? 2'h0 : r;
      axi_wr(rxcke_pkg::REG_RATE_OFF, {26'h0, r, r, r}, rxcke_pkg::RESP_OKAY);
      axi_rd(rxcke_pkg::REG_RATE_OFF, {26'h0, r, r, r}, rxcke_pkg::RESP_OKAY);
      single_freq_enable <= k[2];
      rx_on_pin <= k[0];
      rx_monitor_pin_in <= k[1];
      repeat (5) @(posedge core_clk);
      #1;
      chk_bus(synth_enable, k[2]);
      chk_bus(clk_source_sel, k[2] ? 6'h3F : {s, s, s});
      chk_bus(synth_rate, {r, r, r});
      chk_bus(rx_on_level, k[0]);
      chk_bus(rx_monitor_level, k[1]);
      axi_rd(rxcke_pkg::REG_STATUS_OFF, {18'h0, k[2] ? 6'h3F : {s, s, s}, 3'h0, k[1], k[0],
        k[2], 2'h0}, rxcke_pkg::RESP_OKAY);
    end
    single_freq_enable <= 1'b0;
    rx_on_pin <= 1'b0;
    // Both edges, dual and single rail
    for (int m = 0; m < 4; m++) begin
      m_rail = m[1];
      axi_wr(rxcke_pkg::REG_CTRL_OFF, {29'h0, m_rail, 2'h0}, rxcke_pkg::RESP_OKAY);
      axi_rd(rxcke_pkg::REG_CTRL_OFF, {29'h0, m_rail, 2'h0}, rxcke_pkg::RESP_OKAY);
      rx_edge_select <= m[0];
      m_fall = m[0];
      repeat (8) @(posedge core_clk);
      repeat (4) lane_bit();
    end
    chk_lane({serial_chip_select_n, rx_monitor_pin_oe, serial_data_in}, 3'h4);
    // Host mode: pins carry serial
    @(posedge core_clk) host_mode_pin <= 1'b1;
    repeat (6) @(posedge core_clk);
    q3 = {};
    for (int t = 0; t < 16; t++) begin
      @(posedge core_clk);
      v = 3'($urandom);
      rx_edge_select <= v[2];
      rx_on_pin <= v[1];
      serial_data_out <= v[0];
      q3.push_back(v);
      #1;
      if (t >= 3) begin
        chk_lane({serial_chip_select_n, serial_data_in, rx_monitor_pin_out},
          {q3[t-3][2:1], q3[t-1][0]});
        chk_bus(rx_monitor_pin_oe, 1'b1);
      end
    end
    // Edge and synthesizer now follow the control word, not the pins
    @(posedge core_clk) rx_edge_select <= 1'b0;
    axi_wr(rxcke_pkg::REG_CTRL_OFF, 32'h3, rxcke_pkg::RESP_OKAY);
    m_fall = 1'b1;
    m_rail = 1'b0;
    repeat (3) @(posedge core_clk);
    repeat (2) lane_bit();
    chk_bus(synth_enable, 1'b1);
    // Second reset in mid-run
    @(posedge core_clk) host_mode_pin <= 1'b0;
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    #1;
    chk_bus(synth_enable, 1'b0);
    axi_rd(rxcke_pkg::REG_CTRL_OFF, 32'h0, rxcke_pkg::RESP_OKAY);
    conclude();
  end

  // Watchdog
  initial begin
    repeat (20000) @(posedge core_clk);
    failures++;
    conclude();
  end
endmodule
`default_nettype wire
